// *** hdl/cfg_pkg.sv ***
package cfg_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int IO_W = 8;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 4;
  localparam int DEPTH = 16;
  localparam int IR_W = 8;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 4'hF;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;
  localparam logic [IR_W-1:0] INS_BYPASS = 8'hFF;
  localparam logic [IR_W-1:0] INS_ENTER_OFFLINE = 8'h10;
  localparam logic [IR_W-1:0] INS_ENTER_BACKGROUND = 8'h11;
  localparam logic [IR_W-1:0] INS_EXIT = 8'h12;
  localparam logic [IR_W-1:0] INS_SET_IO = 8'h13;
  localparam logic [IR_W-1:0] INS_NVM_ERASE = 8'h20;
  localparam logic [IR_W-1:0] INS_NVM_WRITE = 8'h21;
  localparam logic [IR_W-1:0] INS_NVM_READ = 8'h22;
  localparam logic [IR_W-1:0] INS_SRAM_ERASE = 8'h30;
  localparam logic [IR_W-1:0] INS_SRAM_WRITE = 8'h31;
  localparam logic [IR_W-1:0] INS_SRAM_READ = 8'h32;
  localparam logic [IR_W-1:0] INS_REFRESH = 8'h40;
  localparam logic [IR_W-1:0] INS_LIVE_UPDATE = 8'h41;
  localparam logic [IR_W-1:0] INS_SECURE = 8'h50;

  // ----------------------------------------------------------------
  // Status word fields
  // ----------------------------------------------------------------
  localparam int STAT_IO_LSB = 0;
  localparam int STAT_SEC_SRAM = 2;
  localparam int STAT_SEC_NVM = 3;
  localparam int STAT_LOADED = 4;
  localparam int STAT_BACKGROUND = 5;
  localparam int STAT_OFFLINE = 6;
  localparam int STAT_BUSY = 7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {IO_HIGH, IO_LOW, IO_TRI, IO_HOLD} io_mode_t;
  localparam io_mode_t IO_MODE_RST = IO_HOLD;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_state_t;

  typedef enum logic {LD_IDLE, LD_COPY} load_state_t;

endpackage : cfg_pkg

// *** hdl/config_mode_control.sv ***
// Summary of operation
// [RULE1] Offline programming of non-volatile store hands all pins to boundary cells.
// [RULE2] Background programming keeps user logic running while non-volatile store changes.
// [RULE3] Power-up copies non-volatile store into configuration memory automatically.
// [RULE4] A refresh command over the test port reloads configuration memory.
// [RULE5] Configuration memory accepts direct serial loading through the test port.
// [RULE6] During programming or reload each pin goes high, low, tristate or holds.
// [RULE7] Set security bits block readback of both memories.
// [RULE8] Security bits clear only when their memory space is erased.
// [RULE9] One live update command replaces user logic with pins held steady.
// [RULE10] Security bits persist across reset and refresh until erase.
`timescale 1ns/1ps
`default_nettype none
module config_mode_control
  import cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Test access pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  // User logic pin requests
  input wire logic [IO_W-1:0] user_io_out,
  input wire logic [IO_W-1:0] user_io_oe,
  // Device pins
  output logic [IO_W-1:0] pin_out,
  output logic [IO_W-1:0] pin_oe,
  // Status
  output logic user_run,
  output logic offline,
  output logic background
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] nvm_mem [DEPTH];
  logic [WORD_W-1:0] sram_mem [DEPTH];
  logic sec_sram_reg, sec_nvm_reg;
  logic [IR_W-1:0] ir_word;
  logic [WORD_W-1:0] dr_word, cap_word;
  logic upd_ir, upd_dr;
  logic offline_reg, background_reg, boot_reg, loaded_reg, live_reg, run_reg;
  io_mode_t io_mode_reg;
  load_state_t ld_state;
  logic [ADDR_W-1:0] ld_cnt, addr_reg;
  logic [IO_W-1:0] cells_out_reg, cells_oe_reg, pin_out_reg, pin_oe_reg;
  logic ld_busy, io_frozen, start_load, nvm_access, cmd;

  function automatic logic [2*IO_W-1:0] fill_cells(input io_mode_t m,
                                                    input logic [2*IO_W-1:0] cur);
    case (m)
      IO_HIGH: fill_cells = {{IO_W{1'b1}}, {IO_W{1'b1}}};
      IO_LOW: fill_cells = {{IO_W{1'b0}}, {IO_W{1'b1}}};
      IO_TRI: fill_cells = {cur[2*IO_W-1:IO_W], {IO_W{1'b0}}};
      default: fill_cells = cur;
    endcase
  endfunction : fill_cells

  scan_port u_scan (
    .clk(clk),
    .rst_b(rst_b),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tdo(tdo),
    .cap_word(cap_word),
    .ir_word(ir_word),
    .dr_word(dr_word),
    .upd_ir(upd_ir),
    .upd_dr(upd_dr)
  );

  assign ld_busy = ld_state == LD_COPY;
  assign io_frozen = offline_reg | ld_busy;
  assign nvm_access = offline_reg | background_reg;
  assign cmd = upd_ir & ~ld_busy;
  assign start_load = !ld_busy && !offline_reg &&
                      (boot_reg || (upd_ir && (ir_word == INS_REFRESH ||
                                               ir_word == INS_LIVE_UPDATE)));

  // ----------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------
  always_comb begin
    cap_word = '0;
    // [RULE7] Secured readback
    if (ir_word == INS_NVM_READ) begin
      cap_word = sec_nvm_reg ? '0 : nvm_mem[addr_reg];
    end else if (ir_word == INS_SRAM_READ) begin
      cap_word = sec_sram_reg ? '0 : sram_mem[addr_reg];
    end else begin
      cap_word[STAT_IO_LSB +: 2] = io_mode_reg;
      cap_word[STAT_SEC_SRAM] = sec_sram_reg;
      cap_word[STAT_SEC_NVM] = sec_nvm_reg;
      cap_word[STAT_LOADED] = loaded_reg;
      cap_word[STAT_BACKGROUND] = background_reg;
      cap_word[STAT_OFFLINE] = offline_reg;
      cap_word[STAT_BUSY] = ld_busy;
    end
  end

  // ----------------------------------------------------------------
  // Modes and address
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      offline_reg <= 1'b0;
      background_reg <= 1'b0;
      io_mode_reg <= IO_MODE_RST;
      addr_reg <= '0;
    end else begin
      if (upd_ir) begin
        addr_reg <= '0;
      end else if (upd_dr && !ld_busy) begin
        addr_reg <= addr_reg + 4'h1;
      end
      if (cmd && ir_word == INS_ENTER_OFFLINE && !background_reg) begin
        offline_reg <= 1'b1;
      end else if (cmd && ir_word == INS_ENTER_BACKGROUND && !offline_reg) begin
        background_reg <= 1'b1;
      end else if (cmd && ir_word == INS_EXIT) begin
        offline_reg <= 1'b0;
        background_reg <= 1'b0;
      end
      if (upd_dr && ir_word == INS_SET_IO) begin
        io_mode_reg <= io_mode_t'(dr_word[1:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Memories and security bits (not reset: they model non-volatile state)
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (cmd && ir_word == INS_NVM_ERASE && nvm_access) begin
      for (int i = 0; i < DEPTH; i++) begin
        nvm_mem[i] <= '0;
      end
    end else if (upd_dr && !ld_busy && ir_word == INS_NVM_WRITE && nvm_access) begin
      nvm_mem[addr_reg] <= dr_word;
    end
  end

  always_ff @(posedge clk) begin
    if (ld_busy) begin
      sram_mem[ld_cnt] <= nvm_mem[ld_cnt];
    end else if (cmd && ir_word == INS_SRAM_ERASE && offline_reg) begin
      for (int i = 0; i < DEPTH; i++) begin
        sram_mem[i] <= '0;
      end
    // [RULE5] Direct serial load
    end else if (upd_dr && ir_word == INS_SRAM_WRITE && offline_reg) begin
      sram_mem[addr_reg] <= dr_word;
    end
  end

  // [RULE8] Clear only by erase
  // [RULE10] No reset on security bits
  always_ff @(posedge clk) begin
    if (cmd && ir_word == INS_SECURE) begin
      sec_nvm_reg <= 1'b1;
      sec_sram_reg <= 1'b1;
    end else if (cmd && ir_word == INS_NVM_ERASE && nvm_access) begin
      sec_nvm_reg <= 1'b0;
    end else if (cmd && ir_word == INS_SRAM_ERASE && offline_reg) begin
      sec_sram_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration load engine
  // ----------------------------------------------------------------
  // [RULE3] Boot load
  // [RULE4] Refresh load
  // [RULE9] Live update load
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ld_state <= LD_IDLE;
      ld_cnt <= '0;
      boot_reg <= 1'b1;
      live_reg <= 1'b0;
      loaded_reg <= 1'b0;
    end else begin
      case (ld_state)
        LD_IDLE: begin
          if (start_load) begin
            ld_state <= LD_COPY;
            ld_cnt <= '0;
            boot_reg <= 1'b0;
            live_reg <= !boot_reg && ir_word == INS_LIVE_UPDATE;
            loaded_reg <= 1'b0;
          end else if (cmd && ir_word == INS_SRAM_ERASE && offline_reg) begin
            loaded_reg <= 1'b0;
          end else if (upd_dr && ir_word == INS_SRAM_WRITE && offline_reg) begin
            loaded_reg <= 1'b1;
          end
        end
        LD_COPY: begin
          ld_cnt <= ld_cnt + 4'h1;
          if (ld_cnt == LAST_ADDR) begin
            ld_state <= LD_IDLE;
            live_reg <= 1'b0;
            loaded_reg <= 1'b1;
          end
        end
        default: ld_state <= LD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin control
  // ----------------------------------------------------------------
  // [RULE6] Pin state during configuration
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cells_out_reg <= '0;
      cells_oe_reg <= '0;
    end else if (upd_dr && ir_word == INS_SET_IO) begin
      {cells_out_reg, cells_oe_reg} <= fill_cells(io_mode_t'(dr_word[1:0]),
        io_frozen ? {pin_out_reg, pin_oe_reg} : {user_io_out, user_io_oe});
    end else if (!io_frozen) begin
      {cells_out_reg, cells_oe_reg} <= fill_cells(io_mode_reg, {user_io_out, user_io_oe});
    end
  end

  // [RULE1] Boundary cells own the pins
  // [RULE2] User logic keeps running in background
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out_reg <= '0;
      pin_oe_reg <= '0;
      run_reg <= 1'b0;
    end else begin
      run_reg <= loaded_reg && !io_frozen;
      if (!io_frozen) begin
        pin_out_reg <= user_io_out;
        pin_oe_reg <= user_io_oe;
      end else if (!live_reg) begin
        pin_out_reg <= cells_out_reg;
        pin_oe_reg <= cells_oe_reg;
      end
    end
  end

  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;
  assign user_run = run_reg;
  assign offline = offline_reg;
  assign background = background_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  offline_pins_a: assert property ( // [RULE1]
    $past(offline_reg) && offline_reg && !live_reg |-> pin_out_reg == $past(cells_out_reg)
      && pin_oe_reg == $past(cells_oe_reg)) else $error("pins not from boundary cells");
  background_run_a: assert property ( // [RULE2]
    background_reg && loaded_reg && !ld_busy |=> run_reg) else $error("user logic stopped");
  boot_load_a: assert property ( // [RULE3]
    boot_reg && !ld_busy |=> ld_busy ##15 ld_busy ##1 !ld_busy && loaded_reg)
    else $error("power-up load missing");
  refresh_load_a: assert property ( // [RULE4]
    upd_ir && ir_word == INS_REFRESH && !ld_busy && !offline_reg |=> ld_busy ##15 ld_busy
      ##1 loaded_reg) else $error("refresh did not reload");
  direct_load_a: assert property ( // [RULE5]
    upd_dr && ir_word == INS_SRAM_WRITE && offline_reg && !ld_busy
      |=> sram_mem[$past(addr_reg)] == $past(dr_word)) else $error("direct load lost");
  io_low_a: assert property ( // [RULE6]
    upd_dr && ir_word == INS_SET_IO && offline_reg && dr_word[1:0] == 2'h1
      |=> ##1 pin_out_reg == '0 && pin_oe_reg == '1) else $error("pins not driven low");
  secure_read_a: assert property ( // [RULE7]
    (sec_sram_reg && ir_word == INS_SRAM_READ) || (sec_nvm_reg && ir_word == INS_NVM_READ)
      |-> cap_word == '0) else $error("secured readback leaked");
  sec_clear_a: assert property ( // [RULE8]
    $fell(sec_nvm_reg) |-> $past(cmd) && $past(ir_word) == INS_NVM_ERASE)
    else $error("security cleared without erase");
  live_hold_a: assert property ( // [RULE9]
    live_reg && $past(live_reg) |-> $stable(pin_out_reg) && $stable(pin_oe_reg))
    else $error("pins moved in live update");
  sec_keep_a: assert property ( // [RULE10]
    disable iff (1'b0) !rst_b && sec_nvm_reg |=> sec_nvm_reg) else $error("security lost");

endmodule : config_mode_control
`default_nettype wire

// *** hdl/scan_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module scan_port
  import cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Test access pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  // Command side
  input wire logic [WORD_W-1:0] cap_word,
  output logic [IR_W-1:0] ir_word,
  output logic [WORD_W-1:0] dr_word,
  output logic upd_ir,
  output logic upd_dr
);

  // ----------------------------------------------------------------
  // Pin sampling (bit 0 tck, bit 1 tms, bit 2 tdi)
  // ----------------------------------------------------------------
  logic [2:0] s1_reg, s2_reg, s3_reg, flt_reg, flt_next;
  logic tck_rise, tck_fall;
  tap_state_t tap_reg, tap_next;
  logic [IR_W-1:0] ir_sr_reg, ir_reg;
  logic [WORD_W-1:0] dr_sr_reg;
  logic upd_ir_reg, upd_dr_reg, tdo_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      s3_reg <= 3'h0;
      flt_reg <= 3'h0;
    end else begin
      s1_reg <= {tdi, tms, tck};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      flt_reg <= flt_next;
    end
  end

  always_comb begin
    flt_next = (~(s2_reg ^ s3_reg) & s2_reg) | ((s2_reg ^ s3_reg) & flt_reg);
    tck_rise = flt_next[0] & ~flt_reg[0];
    tck_fall = ~flt_next[0] & flt_reg[0];
    case (tap_reg)
      TAP_RESET: tap_next = flt_next[1] ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_next = flt_next[1] ? SEL_DR : TAP_IDLE;
      SEL_DR: tap_next = flt_next[1] ? SEL_IR : CAP_DR;
      CAP_DR: tap_next = flt_next[1] ? EX1_DR : SH_DR;
      SH_DR: tap_next = flt_next[1] ? EX1_DR : SH_DR;
      EX1_DR: tap_next = flt_next[1] ? UPD_DR : PA_DR;
      PA_DR: tap_next = flt_next[1] ? EX2_DR : PA_DR;
      EX2_DR: tap_next = flt_next[1] ? UPD_DR : SH_DR;
      UPD_DR: tap_next = flt_next[1] ? SEL_DR : TAP_IDLE;
      SEL_IR: tap_next = flt_next[1] ? TAP_RESET : CAP_IR;
      CAP_IR: tap_next = flt_next[1] ? EX1_IR : SH_IR;
      SH_IR: tap_next = flt_next[1] ? EX1_IR : SH_IR;
      EX1_IR: tap_next = flt_next[1] ? UPD_IR : PA_IR;
      PA_IR: tap_next = flt_next[1] ? EX2_IR : PA_IR;
      EX2_IR: tap_next = flt_next[1] ? UPD_IR : SH_IR;
      UPD_IR: tap_next = flt_next[1] ? SEL_DR : TAP_IDLE;
      default: tap_next = TAP_RESET;
    endcase
  end

  // ----------------------------------------------------------------
  // Controller state and shift paths
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tap_reg <= TAP_RESET;
    end else if (tck_rise) begin
      tap_reg <= tap_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ir_sr_reg <= IR_CAPTURE;
      dr_sr_reg <= '0;
      ir_reg <= INS_BYPASS;
      upd_ir_reg <= 1'b0;
      upd_dr_reg <= 1'b0;
    end else begin
      upd_ir_reg <= tck_rise && tap_next == UPD_IR;
      upd_dr_reg <= tck_rise && tap_next == UPD_DR;
      if (tck_rise) begin
        case (tap_reg)
          CAP_DR: dr_sr_reg <= cap_word;
          SH_DR: dr_sr_reg <= {flt_next[2], dr_sr_reg[WORD_W-1:1]};
          CAP_IR: ir_sr_reg <= IR_CAPTURE;
          SH_IR: ir_sr_reg <= {flt_next[2], ir_sr_reg[IR_W-1:1]};
          default: ir_sr_reg <= ir_sr_reg;
        endcase
        if (tap_next == UPD_IR) begin
          ir_reg <= ir_sr_reg;
        end else if (tap_next == TAP_RESET) begin
          ir_reg <= INS_BYPASS;
        end
      end
    end
  end

  // Output changes on the falling test clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tdo_reg <= 1'b0;
    end else if (tck_fall) begin
      if (tap_reg == SH_IR) begin
        tdo_reg <= ir_sr_reg[0];
      end else if (tap_reg == SH_DR) begin
        tdo_reg <= dr_sr_reg[0];
      end
    end
  end

  assign tdo = tdo_reg;
  assign ir_word = ir_reg;
  assign dr_word = dr_sr_reg;
  assign upd_ir = upd_ir_reg;
  assign upd_dr = upd_dr_reg;

endmodule : scan_port
`default_nettype wire

// *** verif/config_mode_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module config_mode_control_tb
  import cfg_pkg::*;
;
  logic clk;
  logic rst_b;
  logic tck, tms, tdi, tdo;
  logic [IO_W-1:0] user_io_out, user_io_oe, pin_out, pin_oe, uo, ue;
  logic user_run, offline, background;
  int fail_count;
  int total_checks;
  int addr_m;
  logic [WORD_W-1:0] nvm_m [DEPTH];
  logic [WORD_W-1:0] sram_m [DEPTH];
  logic sec_s, sec_n, off_m, bg_m;
  logic [1:0] io_m;
  logic [IR_W-1:0] ir_m;

  always #5 clk = ~clk;

  config_mode_control u_dut (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .user_io_out(user_io_out), .user_io_oe(user_io_oe), .pin_out(pin_out),
    .pin_oe(pin_oe), .user_run(user_run), .offline(offline), .background(background));

  scan_host #(.HALF(6)) host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  // ------------------------------------------------------------
  // Checking and model
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic cmd(input logic [IR_W-1:0] code);
    logic [IR_W-1:0] cap;
    host.ir_scan(code, cap);
    chk({8'h00, cap}, {8'h00, IR_CAPTURE});
    ir_m = code;
    addr_m = 0;
    case (code)
      INS_ENTER_OFFLINE: if (!bg_m) off_m = 1'b1;
      INS_ENTER_BACKGROUND: if (!off_m) bg_m = 1'b1;
      INS_NVM_ERASE: if (off_m || bg_m) begin
        sec_n = 1'b0;
        foreach (nvm_m[i]) nvm_m[i] = 16'h0000;
      end
      INS_SRAM_ERASE: if (off_m) begin
        sec_s = 1'b0;
        foreach (sram_m[i]) sram_m[i] = 16'h0000;
      end
      INS_SECURE: {sec_s, sec_n} = 2'h3;
      INS_EXIT: {off_m, bg_m} = 2'h0;
      default: ;
    endcase
    repeat (2) @(negedge clk);
  endtask : cmd

  task automatic data(input logic [WORD_W-1:0] din);
    logic [WORD_W-1:0] w;
    logic [WORD_W-1:0] e;
    host.dr_scan(din, w);
    e = (ir_m == INS_NVM_READ) ? (sec_n ? 16'h0000 : nvm_m[addr_m])
                               : (sec_s ? 16'h0000 : sram_m[addr_m]);
    if (ir_m == INS_NVM_READ || ir_m == INS_SRAM_READ)
      chk(w, e);
    if (ir_m == INS_NVM_WRITE && (off_m || bg_m))
      nvm_m[addr_m] = din;
    if (ir_m == INS_SRAM_WRITE && off_m)
      sram_m[addr_m] = din;
    if (ir_m == INS_SET_IO)
      io_m = din[1:0];
    addr_m = (addr_m + 1) % DEPTH;
  endtask : data

  task automatic burst(input logic [IR_W-1:0] code, input int n);
    cmd(code);
    repeat (n) data(16'($urandom));
  endtask : burst

  task automatic stat();
    logic [WORD_W-1:0] w;
    cmd(IR_CAPTURE);
    host.dr_scan(16'h0000, w);
    chk(w & 16'h00EF, {8'h00, 1'b0, off_m, bg_m, 1'b0, sec_n, sec_s, io_m});
  endtask : stat

  task automatic follow();
    user_io_out = 8'($urandom);
    user_io_oe = 8'($urandom);
    repeat (2) @(negedge clk);
    chk({pin_oe, pin_out}, {user_io_oe, user_io_out});
  endtask : follow

  task automatic rst();
    int k;
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    chk({pin_oe, pin_out}, 16'h0000);
    chk({13'h0000, user_run, offline, background}, 16'h0000);
    rst_b = 1'b1;
    {off_m, bg_m} = 2'h0;
    io_m = IO_MODE_RST;
    sram_m = nvm_m;
    k = 0;
    while (user_run !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    chk({15'h0000, user_run}, 16'h0001);
    // Scan controller restarts in its reset state
    host.tap_reset();
  endtask : rst

  task automatic reload(input logic [IR_W-1:0] code, input logic [7:0] eo, input logic [7:0] ee);
    int k;
    fork
      cmd(code);
      begin
        k = 0;
        while (user_run !== 1'b0 && k < 300) begin
          @(negedge clk);
          k++;
        end
        user_io_out = ~user_io_out;
        user_io_oe = ~user_io_oe;
        repeat (3) @(negedge clk);
        chk({pin_oe, pin_out}, {ee, eo});
        chk({15'h0000, user_run}, 16'h0000);
      end
    join
    k = 0;
    while (user_run !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    chk({15'h0000, user_run}, 16'h0001);
    sram_m = nvm_m;
  endtask : reload

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    user_io_out = 8'h00;
    user_io_oe = 8'h00;
    fail_count = 0;
    total_checks = 0;
    {sec_s, sec_n} = 2'h0;
    void'($urandom(47177));
    rst();
    follow();
    host.tap_reset();
    cmd(INS_ENTER_OFFLINE);
    chk({14'h0000, offline, user_run}, 16'h0002);
    cmd(INS_NVM_ERASE);
    cmd(INS_SRAM_ERASE);
    burst(INS_NVM_WRITE, 16);
    burst(INS_NVM_READ, 16);
    burst(INS_SRAM_WRITE, 16);
    burst(INS_SRAM_READ, 16);
    cmd(INS_EXIT);
    rst();
    host.tap_reset();
    cmd(INS_ENTER_OFFLINE);
    burst(INS_SRAM_READ, 4);
    cmd(INS_EXIT);
    for (int m = 0; m < 4; m++) begin
      cmd(INS_SET_IO);
      data(16'(m));
      follow();
      uo = user_io_out;
      ue = user_io_oe;
      cmd(INS_ENTER_OFFLINE);
      user_io_out = ~uo;
      user_io_oe = ~ue;
      repeat (3) @(negedge clk);
      chk({pin_oe, pin_out}, {m < 2 ? 8'hFF : (m == 2 ? 8'h00 : ue),
                             m == 0 ? 8'hFF : (m == 1 ? 8'h00 : uo)});
      cmd(INS_EXIT);
    end
    cmd(INS_ENTER_OFFLINE);
    cmd(INS_SET_IO);
    data(16'h0001);
    chk({pin_oe, pin_out}, 16'hFF00);
    burst(INS_SRAM_WRITE, 4);
    cmd(INS_EXIT);
    reload(INS_REFRESH, 8'h00, 8'hFF);
    cmd(INS_ENTER_OFFLINE);
    burst(INS_SRAM_READ, 4);
    burst(INS_SRAM_WRITE, 4);
    cmd(INS_EXIT);
    reload(INS_LIVE_UPDATE, user_io_out, user_io_oe);
    cmd(INS_ENTER_OFFLINE);
    burst(INS_SRAM_READ, 4);
    cmd(INS_EXIT);
    cmd(INS_ENTER_BACKGROUND);
    cmd(INS_ENTER_OFFLINE);
    chk({13'h0000, background, user_run, offline}, 16'h0006);
    cmd(INS_NVM_WRITE);
    repeat (4) begin
      data(16'($urandom));
      follow();
    end
    burst(INS_NVM_READ, 4);
    cmd(INS_EXIT);
    cmd(INS_SECURE);
    stat();
    cmd(INS_ENTER_OFFLINE);
    burst(INS_NVM_READ, 2);
    burst(INS_SRAM_READ, 2);
    cmd(INS_EXIT);
    rst();
    stat();
    reload(INS_REFRESH, user_io_out, user_io_oe);
    stat();
    cmd(INS_ENTER_OFFLINE);
    cmd(INS_SRAM_ERASE);
    stat();
    burst(INS_SRAM_READ, 2);
    cmd(INS_NVM_ERASE);
    stat();
    close_out();
  end

  // Budget is about twice the expected run length
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    close_out();
  end
endmodule : config_mode_control_tb
`default_nettype wire

// *** verif/scan_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module scan_host
  import cfg_pkg::*;
#(
  parameter int HALF = 6
) (
  // Clock
  input wire logic clk,
  // Test access pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // ------------------------------------------------------------
  // Test clock cycles, idle low between frames
  // ------------------------------------------------------------
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  task automatic tick(input logic m, input logic d, output logic o);
    @(negedge clk);
    tms = m;
    tdi = d;
    repeat (HALF) @(negedge clk);
    o = tdo;
    tck = 1'b1;
    repeat (HALF) @(negedge clk);
    tck = 1'b0;
  endtask : tick

  task automatic tap_reset();
    logic o;
    repeat (5) tick(1'b1, tdi, o);
    tick(1'b0, tdi, o);
  endtask : tap_reset

  task automatic shift(input logic ir, input int n, input logic [WORD_W-1:0] din,
                       output logic [WORD_W-1:0] dout);
    logic o;
    dout = 16'h0000;
    tick(1'b1, tdi, o);
    if (ir)
      tick(1'b1, tdi, o);
    tick(1'b0, tdi, o);
    tick(1'b0, tdi, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'b1, tdi, o);
    tick(1'b0, tdi, o);
    // Released data line shows the inverse of its last bit
    tdi = ~tdi;
  endtask : shift

  task automatic ir_scan(input logic [IR_W-1:0] code, output logic [IR_W-1:0] cap);
    logic [WORD_W-1:0] w;
    shift(1'b1, IR_W, {{(WORD_W-IR_W){1'b0}}, code}, w);
    cap = w[IR_W-1:0];
  endtask : ir_scan

  task automatic dr_scan(input logic [WORD_W-1:0] din, output logic [WORD_W-1:0] dout);
    shift(1'b0, WORD_W, din, dout);
  endtask : dr_scan
endmodule : scan_host
`default_nettype wire
